// File: design/mps_sequencer.sv
// Top of the multiphase pwm sequencer: strap, slot timebase, channels, protection.
// Assumes all inputs synchronous to clk; comparator and sense values digitised.
`timescale 1ns/1ns
`default_nettype none

module mps_sequencer (
	// Clock, reset and enable
	input  wire logic                        clk,
	input  wire logic                        srst,
	input  wire logic                        ce,
	// Strap sensed on the third phase pin
	input  wire logic                        third_tied,
	// Error amplifier level in ramp cycles
	input  wire logic [mps_pkg::LVL_W-1:0]   error_amp_level,
	// Digitised sense inputs
	input  wire logic [mps_pkg::SEN_W-1:0]   current_sense_input_first,
	input  wire logic [mps_pkg::SEN_W-1:0]   current_sense_input_second,
	input  wire logic [mps_pkg::SEN_W-1:0]   current_sense_input_third,
	// Overcurrent limit per channel
	input  wire logic [mps_pkg::SEN_W-1:0]   oc_limit,
	// Phase outputs to the drivers
	output logic                             phase_out_first,
	output logic                             phase_out_second,
	output logic                             phase_out_third,
	// Sample windows
	output logic                             window_first,
	output logic                             window_second,
	output logic                             window_third,
	// Held samples
	output logic [mps_pkg::SEN_W-1:0]        held_first,
	output logic [mps_pkg::SEN_W-1:0]        held_second,
	output logic [mps_pkg::SEN_W-1:0]        held_third,
	// Cycle results
	output logic [mps_pkg::SEN_W-1:0]        cycle_average_current,
	output logic [mps_pkg::SUM_W-1:0]        load_line_sum,
	output logic                             overcurrent,
	output logic                             two_phase_mode,
	output logic                             cycle_start
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	mps_pkg::mps_state_e                 state;
	mps_pkg::mps_state_e                 next_state;
	logic                                two_phase;
	logic                                run;
	logic [mps_pkg::CNT_W-1:0]           slot_cnt;
	logic [mps_pkg::SLOT_W-1:0]          slot_idx;
	logic                                slot_edge;
	logic [mps_pkg::SLOT_W-1:0]          ofs [mps_pkg::NCH];
	logic [mps_pkg::SLOT_W-1:0]          rel [mps_pkg::NCH];
	logic [mps_pkg::AGE_W-1:0]           age [mps_pkg::NCH];
	logic [mps_pkg::NCH-1:0]             active;
	logic [mps_pkg::NCH-1:0]             fall;
	logic [mps_pkg::NCH-1:0]             off_end;
	logic [mps_pkg::NCH-1:0]             win_open;
	logic [mps_pkg::NCH-1:0]             win_close;
	logic [mps_pkg::NCH-1:0]             ph;
	logic [mps_pkg::NCH-1:0]             win;
	logic [mps_pkg::SEN_W-1:0]           sense [mps_pkg::NCH];
	logic [mps_pkg::SEN_W-1:0]           held [mps_pkg::NCH];
	logic [mps_pkg::SEN_W-1:0]           avg;
	logic                                avg_stb;
	logic [mps_pkg::SUM_W-1:0]           sum;
	logic                                next_oc;

	// Slot distance from a channel's fall slot, modulo six.
	function automatic logic [mps_pkg::SLOT_W-1:0] rel_slot(
		input logic [mps_pkg::SLOT_W-1:0] idx,
		input logic [mps_pkg::SLOT_W-1:0] off
	);
		logic [mps_pkg::SLOT_W:0] d;
		d = {1'b0, idx} + (mps_pkg::SLOT_W+1)'(mps_pkg::SLOTS) - {1'b0, off};
		if (d >= (mps_pkg::SLOT_W+1)'(mps_pkg::SLOTS)) begin
			d = d - (mps_pkg::SLOT_W+1)'(mps_pkg::SLOTS);
		end
		return d[mps_pkg::SLOT_W-1:0];
	endfunction : rel_slot

	// ----------------------------------------
	// Start-up and strap
	// ----------------------------------------

	// Reset, then one cycle to catch the strap, then run.
	always_comb begin
		next_state = state;
		unique case (state)
			mps_pkg::MPS_IDLE:  next_state = mps_pkg::MPS_STRAP;
			mps_pkg::MPS_STRAP: next_state = mps_pkg::MPS_RUN;
			mps_pkg::MPS_RUN:   next_state = mps_pkg::MPS_RUN;
			default:            next_state = mps_pkg::MPS_IDLE;
		endcase
	end

	// State register.
	always_ff @(posedge clk) begin
		if (srst) begin
			state <= mps_pkg::MPS_IDLE;
		end else if (ce) begin
			state <= next_state;
		end
	end

	// The strap is sampled once after release and then held.
	always_ff @(posedge clk) begin
		if (srst) begin
			two_phase <= 1'b0;
		end else if (ce && state == mps_pkg::MPS_STRAP) begin
			two_phase <= third_tied;
		end
	end

	assign run = (state == mps_pkg::MPS_RUN);

	// ----------------------------------------
	// Slot timebase
	// ----------------------------------------

	// Six equal slots make one switching period.
	always_ff @(posedge clk) begin
		if (srst) begin
			slot_cnt <= mps_pkg::CNT_ZERO;
			slot_idx <= mps_pkg::SLOT_ZERO;
		end else if (ce && run) begin
			if (slot_cnt == mps_pkg::CNT_LAST) begin
				slot_cnt <= mps_pkg::CNT_ZERO;
				if (slot_idx == mps_pkg::SLOT_LAST) begin
					slot_idx <= mps_pkg::SLOT_ZERO;
				end else begin
					slot_idx <= slot_idx + 3'h1;
				end
			end else begin
				slot_cnt <= slot_cnt + 6'h01;
			end
		end
	end

	assign slot_edge = run && (slot_cnt == mps_pkg::CNT_ZERO);

	// Fall slot of each channel for the selected channel count.
	always_comb begin
		ofs[0] = mps_pkg::OFS_FIRST;
		if (two_phase) begin
			ofs[1] = mps_pkg::OFS2_SECOND;
		end else begin
			ofs[1] = mps_pkg::OFS3_SECOND;
		end
		ofs[2] = mps_pkg::OFS3_THIRD;
	end

	// ----------------------------------------
	// Channels
	// ----------------------------------------
	assign sense[0] = current_sense_input_first;
	assign sense[1] = current_sense_input_second;
	assign sense[2] = current_sense_input_third;

	for (genvar ch = 0; ch < mps_pkg::NCH; ch++) begin : g_ch
		// Per-channel events decoded from the slot distance.
		always_comb begin
			rel[ch]       = rel_slot(slot_idx, ofs[ch]);
			age[ch]       = mps_pkg::AGE_W'(rel[ch] * mps_pkg::SLOT_CYC) + {3'h0, slot_cnt};
			active[ch]    = run && (ch < mps_pkg::NCH - 1 || !two_phase);
			fall[ch]      = slot_edge && rel[ch] == mps_pkg::REL_FALL;
			off_end[ch]   = slot_edge && rel[ch] == mps_pkg::REL_OFF_END;
			win_open[ch]  = slot_edge && rel[ch] == mps_pkg::REL_WIN_OPEN;
			win_close[ch] = slot_edge && rel[ch] == mps_pkg::REL_WIN_CLOSE;
		end

		mps_channel u_ch (
			.clk       (clk),
			.srst      (srst),
			.ce        (ce),
			.active    (active[ch]),
			.fall      (fall[ch]),
			.off_end   (off_end[ch]),
			.win_open  (win_open[ch]),
			.win_close (win_close[ch]),
			.age       (age[ch]),
			.level     (error_amp_level),
			.sense     (sense[ch]),
			.avg       (avg),
			.avg_stb   (avg_stb),
			.phase_out (ph[ch]),
			.window    (win[ch]),
			.held      (held[ch]),
			.corr      ()
		);
	end

	// ----------------------------------------
	// Cycle average
	// ----------------------------------------
	mps_average u_avg (
		.clk       (clk),
		.srst      (srst),
		.ce        (ce),
		.start     (cycle_start),
		.two_phase (two_phase),
		.held_a    (held[0]),
		.held_b    (held[1]),
		.held_c    (held[2]),
		.avg       (avg),
		.avg_stb   (avg_stb),
		.sum_out   (sum)
	);

	// ----------------------------------------
	// Protection and cycle flags
	// ----------------------------------------

	// Any active held sample above the limit flags overcurrent.
	always_comb begin
		next_oc = 1'b0;
		for (int i = 0; i < mps_pkg::NCH; i++) begin
			if (active[i] && held[i] > oc_limit) begin
				next_oc = 1'b1;
			end
		end
	end

	// Registered flags: cycle start follows the first channel's fall.
	always_ff @(posedge clk) begin
		if (srst) begin
			overcurrent    <= 1'b0;
			cycle_start    <= 1'b0;
			two_phase_mode <= 1'b0;
		end else if (ce) begin
			overcurrent    <= next_oc;
			cycle_start    <= fall[0];
			two_phase_mode <= two_phase;
		end
	end

	// Submodule outputs are flip-flops and pass straight out.
	assign phase_out_first       = ph[0];
	assign phase_out_second      = ph[1];
	assign phase_out_third       = ph[2];
	assign window_first          = win[0];
	assign window_second         = win[1];
	assign window_third          = win[2];
	assign held_first            = held[0];
	assign held_second           = held[1];
	assign held_third            = held[2];
	assign cycle_average_current = avg;
	assign load_line_sum         = sum;

endmodule : mps_sequencer

`default_nettype wire

// File: design/mps_pkg.sv
// Constants, widths and state codes for the multiphase pwm sequencer.
// Assumes a 50 MHz clock and digitised comparator and sense inputs.
// Summary of operation
// - Three channels run unless two-phase is strapped.
// - Cycle starts when first phase output falls.
// - Three-phase falls are spaced one third cycle.
// - Third pin tied high selects two half-spaced channels.
// - Each fallen output stays low one third cycle.
// - After off-time, corrected level crossing ramp raises output.
// - Output stays high until its next fall event.
// - Sample window opens one sixth after fall.
// - Sample window stays open one sixth period.
// - Capture at window close, hold one period.
// - Held samples feed balance, load line, overcurrent.
// - Sensing per channel; third idle in two-phase.
// - Average of active held samples each cycle.
// - Filtered sample-minus-average error trims pulse width.

package mps_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int SW_PERIOD_NS  = 7680;
	localparam int PERIOD_CYC    = SW_PERIOD_NS / CLK_PERIOD_NS;
	localparam int SLOTS         = 6;
	localparam int SLOT_CYC      = PERIOD_CYC / SLOTS;
	localparam int MAX_ON        = PERIOD_CYC - 2 * SLOT_CYC;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int AGE_W  = 9;
	localparam int CNT_W  = 6;
	localparam int SLOT_W = 3;
	localparam int LVL_W  = 9;
	localparam int SEN_W  = 10;
	localparam int SUM_W  = 12;
	localparam int COR_W  = 10;
	localparam int NCH    = 3;

	// ----------------------------------------
	// Slot positions
	// ----------------------------------------
	localparam logic [CNT_W-1:0]  CNT_LAST      = CNT_W'(SLOT_CYC - 1);
	localparam logic [CNT_W-1:0]  CNT_ZERO      = 6'h00;
	localparam logic [SLOT_W-1:0] SLOT_LAST     = SLOT_W'(SLOTS - 1);
	localparam logic [SLOT_W-1:0] SLOT_ZERO     = 3'h0;
	localparam logic [SLOT_W-1:0] OFS_FIRST     = 3'h0;
	localparam logic [SLOT_W-1:0] OFS3_SECOND   = 3'h2;
	localparam logic [SLOT_W-1:0] OFS3_THIRD    = 3'h4;
	localparam logic [SLOT_W-1:0] OFS2_SECOND   = 3'h3;
	localparam logic [SLOT_W-1:0] REL_FALL      = 3'h0;
	localparam logic [SLOT_W-1:0] REL_WIN_OPEN  = 3'h1;
	localparam logic [SLOT_W-1:0] REL_WIN_CLOSE = 3'h2;
	localparam logic [SLOT_W-1:0] REL_OFF_END   = 3'h2;

	// ----------------------------------------
	// Arithmetic
	// ----------------------------------------
	localparam logic [SUM_W-1:0] DIV3_MUL   = 12'haab;
	localparam int               DIV3_SHIFT = 13;
	localparam int               FILT_SHIFT = 3;
	localparam int               COR_MAX    = 127;

	// ----------------------------------------
	// Start-up sequence
	// ----------------------------------------
	typedef enum logic [1:0] {
		MPS_IDLE  = 2'h0,
		MPS_STRAP = 2'h1,
		MPS_RUN   = 2'h3
	} mps_state_e;

endpackage : mps_pkg

// File: design/mps_channel.sv
// One phase channel: output latch, off-time, sample and hold, balance filter.
// Assumes timing pulses from the shared slot counter in the top module.
`timescale 1ns/1ns
`default_nettype none

module mps_channel (
	// Clock and control
	input  wire logic                            clk,
	input  wire logic                            srst,
	input  wire logic                            ce,
	input  wire logic                            active,
	// Timing events
	input  wire logic                            fall,
	input  wire logic                            off_end,
	input  wire logic                            win_open,
	input  wire logic                            win_close,
	input  wire logic [mps_pkg::AGE_W-1:0]       age,
	// Front end
	input  wire logic [mps_pkg::LVL_W-1:0]       level,
	input  wire logic [mps_pkg::SEN_W-1:0]       sense,
	// Cycle average
	input  wire logic [mps_pkg::SEN_W-1:0]       avg,
	input  wire logic                            avg_stb,
	// Results
	output logic                                 phase_out,
	output logic                                 window,
	output logic [mps_pkg::SEN_W-1:0]            held,
	output logic signed [mps_pkg::COR_W-1:0]     corr
);

	logic                                armed;
	logic signed [mps_pkg::COR_W+1:0]    demand;
	logic [mps_pkg::AGE_W:0]             dem_c;
	logic [mps_pkg::AGE_W:0]             thr;
	logic                                fire;
	logic signed [mps_pkg::SEN_W+1:0]    err;
	logic signed [mps_pkg::COR_W+1:0]    next_corr;

	// Demand is the error level less the balance trim, clamped to the on-time room.
	always_comb begin
		demand = $signed({3'h0, level}) - $signed({{2{corr[mps_pkg::COR_W-1]}}, corr});
		if (demand < 0) begin
			dem_c = '0;
		end else if (demand > (mps_pkg::COR_W+2)'(mps_pkg::MAX_ON)) begin
			dem_c = (mps_pkg::AGE_W+1)'(mps_pkg::MAX_ON);
		end else begin
			dem_c = demand[mps_pkg::AGE_W:0];
		end
		thr  = (mps_pkg::AGE_W+1)'(mps_pkg::PERIOD_CYC) - dem_c;
		fire = {1'b0, age} >= thr;
	end

	// Balance error against the average, filtered by a clamped integrator.
	always_comb begin
		err       = $signed({2'h0, held}) - $signed({2'h0, avg});
		next_corr = $signed({{2{corr[mps_pkg::COR_W-1]}}, corr}) + (err >>> mps_pkg::FILT_SHIFT);
		if (next_corr > (mps_pkg::COR_W+2)'(mps_pkg::COR_MAX)) begin
			next_corr = (mps_pkg::COR_W+2)'(mps_pkg::COR_MAX);
		end else if (next_corr < -(mps_pkg::COR_W+2)'(mps_pkg::COR_MAX)) begin
			next_corr = -(mps_pkg::COR_W+2)'(mps_pkg::COR_MAX);
		end
	end

	// Off-time arming: firing is blocked from each fall until the off-time ends.
	always_ff @(posedge clk) begin
		if (srst) begin
			armed <= 1'b0;
		end else if (ce) begin
			if (!active || fall) begin
				armed <= 1'b0;
			end else if (off_end) begin
				armed <= 1'b1;
			end
		end
	end

	// Phase output: low on the fall event, high on a crossing once armed.
	always_ff @(posedge clk) begin
		if (srst) begin
			phase_out <= 1'b0;
		end else if (ce) begin
			if (!active || fall) begin
				phase_out <= 1'b0;
			end else if (armed && fire) begin
				phase_out <= 1'b1;
			end
		end
	end

	// Sample window and captured value.
	always_ff @(posedge clk) begin
		if (srst) begin
			window <= 1'b0;
			held   <= '0;
		end else if (ce) begin
			if (!active || win_close) begin
				window <= 1'b0;
			end else if (win_open) begin
				window <= 1'b1;
			end
			if (active && win_close) begin
				held <= sense;
			end
		end
	end

	// Balance trim updates once per cycle with the new average.
	always_ff @(posedge clk) begin
		if (srst) begin
			corr <= '0;
		end else if (ce) begin
			if (!active) begin
				corr <= '0;
			end else if (avg_stb) begin
				corr <= next_corr[mps_pkg::COR_W-1:0];
			end
		end
	end

endmodule : mps_channel

`default_nettype wire

// File: design/mps_average.sv
// Cycle sum and average of the held channel samples.
// Assumes start pulses once per switching cycle.
`timescale 1ns/1ns
`default_nettype none

module mps_average (
	// Clock and control
	input  wire logic                        clk,
	input  wire logic                        srst,
	input  wire logic                        ce,
	input  wire logic                        start,
	input  wire logic                        two_phase,
	// Held samples
	input  wire logic [mps_pkg::SEN_W-1:0]   held_a,
	input  wire logic [mps_pkg::SEN_W-1:0]   held_b,
	input  wire logic [mps_pkg::SEN_W-1:0]   held_c,
	// Results
	output logic [mps_pkg::SEN_W-1:0]        avg,
	output logic                             avg_stb,
	output logic [mps_pkg::SUM_W-1:0]        sum_out
);

	logic [mps_pkg::SUM_W-1:0]   sum;
	logic [2*mps_pkg::SUM_W-1:0] prod;

	// The third sample drops out of the sum in two-phase mode.
	always_comb begin
		sum = {2'h0, held_a} + {2'h0, held_b};
		if (!two_phase) begin
			sum = sum + {2'h0, held_c};
		end
		prod = sum * {12'h000, mps_pkg::DIV3_MUL}; // Exact divide by three over the sum range.
	end

	// Average, strobe and load-line sum register once per cycle.
	always_ff @(posedge clk) begin
		if (srst) begin
			avg     <= '0;
			avg_stb <= 1'b0;
			sum_out <= '0;
		end else if (ce) begin
			avg_stb <= start;
			if (start) begin
				sum_out <= sum;
				if (two_phase) begin
					avg <= sum[mps_pkg::SEN_W:1];
				end else begin
					avg <= prod[mps_pkg::DIV3_SHIFT +: mps_pkg::SEN_W];
				end
			end
		end
	end

endmodule : mps_average

`default_nettype wire

// File: verification/mps_seq_props.sv
// Concurrent checks on the sequencer top ports.
// Assumes ce stays high and inputs change only at clock edges.
`timescale 1ns/1ns
`default_nettype none

module mps_seq_props (
	// Clock and reset
	input wire logic                       clk,
	input wire logic                       srst,
	// Phase and window outputs
	input wire logic                       phase_out_first,
	input wire logic                       phase_out_second,
	input wire logic                       phase_out_third,
	input wire logic                       window_first,
	input wire logic                       window_third,
	// Samples and cycle results
	input wire logic [mps_pkg::SEN_W-1:0]  current_sense_input_first,
	input wire logic [mps_pkg::SEN_W-1:0]  oc_limit,
	input wire logic [mps_pkg::SEN_W-1:0]  held_first,
	input wire logic [mps_pkg::SEN_W-1:0]  held_second,
	input wire logic [mps_pkg::SEN_W-1:0]  held_third,
	input wire logic [mps_pkg::SEN_W-1:0]  cycle_average_current,
	input wire logic [mps_pkg::SUM_W-1:0]  load_line_sum,
	input wire logic                       overcurrent,
	input wire logic                       two_phase_mode,
	input wire logic                       cycle_start
);
	// ----------------------------------------
	// Helper logic
	// ----------------------------------------
	logic [8:0]  age_cnt;
	logic [8:0]  low_cnt;
	logic [11:0] sum3;
	logic        oc_any;

	// Cycles since the last cycle start; saturates so it never wraps.
	always_ff @(posedge clk) begin
		if (srst)
			age_cnt <= 9'h000;
		else if (cycle_start)
			age_cnt <= 9'h001;
		else if (age_cnt != 9'h1ff)
			age_cnt <= age_cnt + 9'h001;
	end

	// Length of the current low stretch of the first phase output.
	always_ff @(posedge clk) begin
		if (srst || phase_out_first)
			low_cnt <= 9'h000;
		else if (low_cnt != 9'h1ff)
			low_cnt <= low_cnt + 9'h001;
	end

	// Sum of active held samples and the overcurrent condition.
	assign sum3 = 12'(held_first) + 12'(held_second) + (two_phase_mode ? 12'h000 : 12'(held_third));
	assign oc_any = (held_first > oc_limit) || (held_second > oc_limit)
		|| (!two_phase_mode && held_third > oc_limit);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking dc @(posedge clk); endclocking
	default disable iff (srst);

	sequence s_win_open;
		##63 !window_first ##1 window_first;
	endsequence

	sequence s_win_close;
		##63 window_first ##1 !window_first;
	endsequence

	a_first_fall: assert property (
		$fell(phase_out_first) |-> cycle_start) else $error("first phase fell off cycle start");
	a_cycle_period: assert property (
		cycle_start |-> ##[384:384] cycle_start) else $error("cycle start period wrong");
	a_second_fall: assert property (
		$fell(phase_out_second) |-> age_cnt == (two_phase_mode ? 9'h0c0 : 9'h080))
		else $error("second phase fell at wrong offset");
	a_third_fall: assert property (
		$fell(phase_out_third) |-> age_cnt == 9'h100) else $error("third phase fell at wrong offset");
	a_off_time: assert property (
		$rose(phase_out_first) |-> low_cnt >= 9'h080) else $error("forced off time too short");
	a_window_timing: assert property (
		cycle_start |-> s_win_open ##0 s_win_close) else $error("sample window timing wrong");
	a_sample_capture: assert property (
		$fell(window_first) |-> held_first == $past(current_sense_input_first))
		else $error("held sample not taken at window close");
	a_sample_hold: assert property (
		!$fell(window_first) |-> $stable(held_first)) else $error("held sample changed between captures");
	a_average_sum: assert property (
		cycle_start |=> load_line_sum == $past(sum3) && cycle_average_current ==
		(two_phase_mode ? 10'($past(sum3) >> 1) : 10'($past(sum3) / 12'h003)))
		else $error("cycle sum or average wrong");
	a_overcurrent: assert property (
		overcurrent == $past(oc_any)) else $error("overcurrent flag wrong");
	a_third_idle: assert property (
		two_phase_mode |-> !phase_out_third && !window_third) else $error("third channel active in two phase");
endmodule : mps_seq_props

`default_nettype wire

// File: verification/mps_drv_model.sv
// Behavioural driver and power stage of one phase, seen as a sense value.
// Assumes phase_in comes straight from a sequencer phase output.
`timescale 1ns/1ns
`default_nettype none

module mps_drv_model #(
	parameter int GAIN = 1
) (
	// Clock and reset
	input wire logic                       clk,
	input wire logic                       srst,
	// Phase command and sensed current
	input wire logic                       phase_in,
	output logic [mps_pkg::SEN_W-1:0]      sense
);
	logic [8:0] on_cnt;
	logic [8:0] last_on;
	logic [1:0] ripple;

	// Current follows the last pulse width; ripple moves it every cycle so a late capture shows.
	always_ff @(posedge clk) begin
		if (srst) begin
			on_cnt <= 9'h000;
			last_on <= 9'h000;
			ripple <= 2'h0;
		end else begin
			ripple <= ripple + 2'h1;
			if (phase_in) begin
				on_cnt <= on_cnt + 9'h001;
			end else if (on_cnt != 9'h000) begin
				last_on <= on_cnt;
				on_cnt <= 9'h000;
			end
		end
	end

	// No current at all until the phase has switched once.
	assign sense = 10'(GAIN * last_on) + ((last_on != 9'h000) ? 10'(ripple) : 10'h000);
endmodule : mps_drv_model

`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench for the sequencer with three phase stage models.
// Assumes the checker and stage model files are compiled first.
`timescale 1ns/1ns
`default_nettype none

module tb_top;
	logic       clk = 1'b0;
	logic       srst = 1'b1;
	logic       ce = 1'b1;
	logic       third_tied = 1'b0;
	logic [8:0] level = 9'h000;
	logic [9:0] lim = 10'h3ff;
	wire [9:0]  s1, s2, s3, h1, h2, h3, avg;
	wire [11:0] sum;
	wire        p1, p2, p3, w1, w2, w3, oc, two, cs;
	int         miscompares = 0;
	int         n_tests = 0;
	int         f2, f3, wr, wf, cst, on1, on2, wo2, hi3;

	// 50 MHz clock.
	always #10 clk = ~clk;

	mps_sequencer mps_sequencer_i (.clk(clk), .srst(srst), .ce(ce), .third_tied(third_tied),
		.error_amp_level(level), .current_sense_input_first(s1), .current_sense_input_second(s2),
		.current_sense_input_third(s3), .oc_limit(lim), .phase_out_first(p1), .phase_out_second(p2),
		.phase_out_third(p3), .window_first(w1), .window_second(w2), .window_third(w3),
		.held_first(h1), .held_second(h2), .held_third(h3), .cycle_average_current(avg),
		.load_line_sum(sum), .overcurrent(oc), .two_phase_mode(two), .cycle_start(cs));
	// The first stage senses twice the current so balance has work to do.
	mps_drv_model #(.GAIN(2)) drv_first (.clk(clk), .srst(srst), .phase_in(p1), .sense(s1));
	mps_drv_model #(.GAIN(1)) drv_second (.clk(clk), .srst(srst), .phase_in(p2), .sense(s2));
	mps_drv_model #(.GAIN(1)) drv_third (.clk(clk), .srst(srst), .phase_in(p3), .sense(s3));

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %0d seen %0d", what, exp, got);
		end
	endtask : chk

	// Waits for the cycle start pulse, at most 500 cycles.
	task automatic wait_start();
		int n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (cs !== 1'b1 && n < 500);
		if (n >= 500) begin
			miscompares++;
			report_and_stop();
		end
	endtask : wait_start

	task automatic do_reset(input logic two_ph);
		@(posedge clk);
		srst <= 1'b1;
		third_tied <= two_ph;
		repeat (20) @(posedge clk);
		srst <= 1'b0;
	endtask : do_reset

	// Times one switching period from a cycle start; checks captures, sum and average.
	task automatic measure(input logic two_ph);
		logic [9:0]  e1, e2, e3;
		logic [11:0] esum;
		logic        q2, q3, qw;
		wait_start();
		f2 = -1;
		f3 = -1;
		wr = -1;
		wf = -1;
		cst = -1;
		on1 = 0;
		on2 = 0;
		wo2 = 0;
		hi3 = 0;
		q2 = p2;
		q3 = p3;
		qw = w1;
		for (int k = 1; k <= 385; k++) begin
			@(posedge clk);
			#1;
			if (q2 && !p2 && f2 < 0) f2 = k;
			if (q3 && !p3 && f3 < 0) f3 = k;
			if (!qw && w1 && wr < 0) wr = k;
			if (qw && !w1 && wf < 0) wf = k;
			if (cs && cst < 0) cst = k;
			on1 += (k <= 384 && p1);
			on2 += (k <= 384 && p2);
			wo2 += (k <= 384 && w2);
			hi3 += (p3 || w3);
			if (k == 127) e1 = s1;
			if (k == 128) chk("held first", e1, h1);
			if (k == (two_ph ? 319 : 255)) e2 = s2;
			if (k == 383) e3 = s3;
			q2 = p2;
			q3 = p3;
			qw = w1;
		end
		esum = 12'(e1) + 12'(e2) + (two_ph ? 12'h000 : 12'(e3));
		chk("sum", esum, sum);
		chk("average", two_ph ? esum >> 1 : esum / 12'h003, avg);
	endtask : measure

	task automatic t_no_demand();
		measure(1'b0);
		chk("on first", 0, on1);
		chk("on second", 0, on2);
	endtask : t_no_demand

	task automatic t_three_phase();
		@(posedge clk);
		level <= 9'h0c8;
		wait_start();
		measure(1'b0);
		chk("second fall", 128, f2);
		chk("third fall", 256, f3);
		chk("window open", 64, wr);
		chk("window close", 128, wf);
		chk("window second", 64, wo2);
		chk("period", 384, cst);
		chk("pulse first", 1, on1 > 0);
		chk("max on first", 1, on1 <= 256);
		@(posedge clk);
		lim <= 10'h000;
		repeat (3) @(posedge clk);
		#1;
		chk("overcurrent set", 1, oc);
		@(posedge clk);
		lim <= 10'h3ff;
		repeat (3) @(posedge clk);
		#1;
		chk("overcurrent clear", 0, oc);
	endtask : t_three_phase

	task automatic t_balance();
		repeat (20) wait_start();
		measure(1'b0);
		chk("heavy phase shorter", 1, on1 < on2);
	endtask : t_balance

	// The strap flag settles a few edges after release, so look at the first cycle start.
	task automatic t_two_phase();
		wait_start();
		chk("two phase flag", 1, two);
		wait_start();
		measure(1'b1);
		chk("second fall", 192, f2);
		chk("third fall", -1, f3);
		chk("third idle", 0, hi3);
	endtask : t_two_phase

	initial begin
		do_reset(1'b0);
		t_no_demand();
		t_three_phase();
		t_balance();
		do_reset(1'b1);
		t_two_phase();
		report_and_stop();
	end
endmodule : tb_top

bind mps_sequencer mps_seq_props mps_seq_props_i (.clk(clk), .srst(srst), .phase_out_first(phase_out_first),
	.phase_out_second(phase_out_second), .phase_out_third(phase_out_third), .window_first(window_first),
	.window_third(window_third), .current_sense_input_first(current_sense_input_first), .oc_limit(oc_limit),
	.held_first(held_first), .held_second(held_second), .held_third(held_third),
	.cycle_average_current(cycle_average_current), .load_line_sum(load_line_sum), .overcurrent(overcurrent),
	.two_phase_mode(two_phase_mode), .cycle_start(cycle_start));

`default_nettype wire
